// *** design/dcm_even_par.sv ***
// Even parity generator: par makes the total count of ones even.
// Pure combinational; used on the internal bus and the scan reply.
`timescale 1ns/1ps
`default_nettype none
module dcm_even_par
#(
   parameter int W = 8
)
(
   input  wire logic [W-1:0] data,
   output logic              par
);
   assign par = ^data;
endmodule
`default_nettype wire

// *** design/dcm_top.sv ***
// Duplex controller maintenance: RAM copy, internal bus parity, output
// comparison, reconfiguration, command decode and scan reply parity.
// Assumes all inputs synchronous to ref_clk; diagnostics run outside.
`timescale 1ns/1ps
`default_nettype none
module dcm_top
   import dcm_pkg::*;
#(
   parameter int DEPTH     = 16,
   parameter int OW        = 8,
   parameter int LINE_N    = 4,
   parameter int CYCLE_LEN = dcm_pkg::CYCLE_CYC
)
(
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   input  wire logic [$clog2(DEPTH)-1:0] ibus_addr,
   input  wire logic                    ibus_rd,
   input  wire logic                    ibus_wr,
   input  wire logic [dcm_pkg::DATA_W:0] ibus_i,
   output logic      [dcm_pkg::DATA_W:0] ibus_o,
   output logic      [dcm_pkg::DATA_W:0] ibus_oe,
   input  wire logic [OW-1:0]           ctl0_out,
   input  wire logic [OW-1:0]           ctl1_out,
   input  wire logic [OW-1:0]           hc0_a,
   input  wire logic [OW-1:0]           hc0_b,
   input  wire logic [OW-1:0]           hc1_a,
   input  wire logic [OW-1:0]           hc1_b,
   output logic      [OW-1:0]           periph_out,
   input  wire logic                    ord_valid,
   input  wire logic [dcm_pkg::CMD_W-1:0] ord_code,
   input  wire logic                    link_app,
   output logic      [dcm_pkg::NCMD-1:0] periph_cmd,
   output logic      [LINE_N-1:0]       line_en,
   input  wire logic                    rm_req,
   input  wire logic                    rm_ctl,
   input  wire dcm_pkg::dcm_rm_type     rm_kind,
   output logic                         rm_refused,
   input  wire logic                    rs_req,
   input  wire logic                    rs_ctl,
   input  wire logic                    cc_force,
   input  wire logic                    cc_force_ctl,
   input  wire logic                    diag_done,
   input  wire logic                    diag_ctl,
   input  wire logic                    diag_pass,
   output logic                         diag_start,
   output logic                         diag_target,
   output logic                         active_ctl,
   output dcm_pkg::dcm_state_type       ctl0_state,
   output dcm_pkg::dcm_state_type       ctl1_state,
   output logic      [1:0]              oos_lamp,
   output logic                         dma_busy,
   output logic                         fault_ind,
   input  wire logic                    scan_req,
   input  wire logic                    scan_normal,
   input  wire logic                    scan_ident,
   input  wire logic [dcm_pkg::SAB_W-1:0] scan_data,
   output logic                         sab_valid,
   output logic      [dcm_pkg::SAB_W-1:0] sab_data,
   output logic                         sab_health,
   output logic                         sab_par,
   output logic                         sab_chk
);
   import dcm_pkg::*;
   localparam int AW = $clog2(DEPTH);

   logic                rst_s1_reg;
   logic                rst_n;
   logic [31:0]         tick_cnt_reg;
   logic                tick;
   logic                pend_reg;
   logic [CMD_W-1:0]    pend_code_reg;
   dcm_state_type       st_reg [2];
   logic                act_reg;
   logic                prt;
   logic [DATA_W-1:0]   ram_reg [2][DEPTH];
   logic                dma_busy_reg;
   logic                dma_tgt_reg;
   logic [AW-1:0]       dma_idx_reg;
   logic                dma_last;
   logic                dma_start;
   logic                dma_start_tgt;
   logic                dma_abort;
   logic                det_on;
   logic                sby_in;
   logic                hc_mis_act;
   logic                hc_mis_sby;
   logic                out_mis;
   logic                mis;
   logic                mis_reg;
   logic                rd_par;
   logic                wr_par;
   logic                par_err;
   logic                scan_par;
   logic                act_fault;
   logic                sby_fault;
   logic                rm_ok;
   logic                rs_ok;

   function automatic logic in_svc(input dcm_state_type s);
      in_svc = (s == ST_ACTIVE) || (s == ST_ACTIVE_MAINTENANCE_REMOVED) || (s == ST_STANDBY);
   endfunction

   // Async assert, synchronous release
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // Program cycle divider
   assign tick = (tick_cnt_reg == 32'(CYCLE_LEN - 1));
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt_reg <= 32'h0;
      else if (tick)
         tick_cnt_reg <= 32'h0;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
   end

   // Orders are held until the cycle tick; both sides accept them alike
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_reg      <= 1'b0;
         pend_code_reg <= '0;
         periph_cmd    <= '0;
         line_en       <= '0;
      end
      else
      begin
         if (ord_valid)
         begin
            pend_reg      <= 1'b1;
            pend_code_reg <= ord_code;
         end
         else if (tick)
            pend_reg <= 1'b0;
         periph_cmd <= '0;
         line_en    <= '0;
         if (tick && pend_reg)
         begin
            periph_cmd <= NCMD'(1) << pend_code_reg;
            if (link_app)
               line_en <= LINE_N'(1) << pend_code_reg[$clog2(LINE_N)-1:0];
         end
      end
   end

   // Comparison at controller and hardcore level
   assign prt        = ~act_reg;
   assign det_on     = (st_reg[act_reg] == ST_ACTIVE);
   assign sby_in     = (st_reg[prt] == ST_STANDBY);
   assign hc_mis_act = act_reg ? (hc1_a != hc1_b) : (hc0_a != hc0_b);
   assign hc_mis_sby = sby_in &&
                       (act_reg ? (hc0_a != hc0_b) : (hc1_a != hc1_b));
   assign out_mis    = sby_in && (ctl0_out != ctl1_out);
   assign mis        = det_on && (out_mis || hc_mis_act || hc_mis_sby);

   dcm_even_par #(.W(DATA_W)) u_rd_par
   (
      .data (ram_reg[act_reg][ibus_addr]),
      .par  (rd_par)
   );
   dcm_even_par #(.W(DATA_W + 1)) u_wr_chk
   (
      .data (ibus_i),
      .par  (wr_par)
   );
   dcm_even_par #(.W(SAB_W)) u_sab_par
   (
      .data (scan_data),
      .par  (scan_par)
   );

   assign par_err   = ibus_wr && wr_par;
   assign act_fault = det_on && (hc_mis_act || par_err ||
                      (diag_done && !diag_pass && diag_ctl == act_reg));
   assign sby_fault = sby_in && (hc_mis_sby ||
                      (diag_done && !diag_pass && diag_ctl == prt));

   // Released word held while an ST_ACTIVE side and an ST_STANDBY side disagree
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         periph_out <= '0;
      else if (!(det_on && out_mis))
         periph_out <= act_reg ? ctl1_out : ctl0_out;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mis_reg     <= 1'b0;
         diag_start  <= 1'b0;
         diag_target <= 1'b0;
         fault_ind   <= 1'b0;
      end
      else
      begin
         mis_reg    <= mis;
         fault_ind  <= par_err;
         diag_start <= (mis && !mis_reg) || (det_on && par_err);
         if (mis && !mis_reg)
            diag_target <= (hc_mis_act || !hc_mis_sby) ? act_reg : prt;
         else if (act_fault || sby_fault)
            diag_target <= act_fault ? act_reg : prt;
      end
   end

   // Only a removal that leaves both in service before it is legal
   assign rm_ok = rm_req && !dma_busy_reg && in_svc(st_reg[0]) &&
                  in_svc(st_reg[1]) && det_on;
   assign rs_ok = rs_req && rs_ctl != act_reg && !in_svc(st_reg[rs_ctl]) &&
                  st_reg[rs_ctl] != ST_OUT_OF_SERVICE_REMOVED && !dma_busy_reg;
   assign dma_start = !dma_busy_reg && (rs_ok || (diag_done && diag_pass &&
                      st_reg[diag_ctl] == ST_OUT_OF_SERVICE_REMOVED));
   assign dma_start_tgt = rs_ok ? rs_ctl : diag_ctl;
   assign dma_abort = cc_force || act_fault;
   assign dma_last  = dma_busy_reg && (dma_idx_reg == AW'(DEPTH - 1));

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg[0] <= RST_ST0;
         st_reg[1] <= RST_ST1;
         act_reg   <= RST_ACT;
      end
      else
      begin
         if (dma_last && !dma_abort)
            st_reg[dma_tgt_reg] <= ST_STANDBY;
         if (cc_force)
         begin
            act_reg              <= cc_force_ctl;
            st_reg[cc_force_ctl] <= ST_ACTIVE;
            if (in_svc(st_reg[~cc_force_ctl]))
               st_reg[~cc_force_ctl] <= ST_OUT_OF_SERVICE_REMOVED;
         end
         else if (act_fault)
         begin
            case (st_reg[prt])
               ST_STANDBY, ST_OS_TEST, ST_OS_HAND:
               begin
                  act_reg          <= prt;
                  st_reg[prt]      <= ST_ACTIVE;
                  st_reg[act_reg]  <= ST_OUT_OF_SERVICE_REMOVED;
               end
               ST_OUT_OF_SERVICE_FAULTED:
               begin
                  act_reg          <= prt;
                  st_reg[prt]      <= ST_ACTIVE_MAINTENANCE_REMOVED;
                  st_reg[act_reg]  <= ST_OUT_OF_SERVICE_REMOVED;
               end
               default:
                  st_reg[act_reg] <= ST_ACTIVE_MAINTENANCE_REMOVED;
            endcase
         end
         else if (sby_fault)
            st_reg[prt] <= ST_OUT_OF_SERVICE_REMOVED;
         else if (diag_done && !diag_pass &&
                  st_reg[diag_ctl] == ST_OUT_OF_SERVICE_REMOVED)
            st_reg[diag_ctl] <= ST_OUT_OF_SERVICE_FAULTED;
         else if (rm_ok)
         begin
            if (rm_ctl == act_reg)
            begin
               act_reg     <= prt;
               st_reg[prt] <= ST_ACTIVE;
            end
            case (rm_kind)
               RM_TEST:   st_reg[rm_ctl] <= ST_OS_TEST;
               RM_HAND:   st_reg[rm_ctl] <= ST_OS_HAND;
               RM_FORCED: st_reg[rm_ctl] <= ST_FORCED;
               default:   st_reg[rm_ctl] <= ST_OUT_OF_SERVICE_REMOVED;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rm_refused <= 1'b0;
      else
         rm_refused <= rm_req && !rm_ok && !cc_force;
   end

   // RAM copy engine, one word per cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dma_busy_reg <= 1'b0;
         dma_tgt_reg  <= 1'b0;
         dma_idx_reg  <= '0;
      end
      else if (dma_busy_reg)
      begin
         dma_idx_reg <= dma_idx_reg + AW'(1);
         if (dma_last || dma_abort)
            dma_busy_reg <= 1'b0;
      end
      else if (dma_start)
      begin
         dma_busy_reg <= 1'b1;
         dma_tgt_reg  <= dma_start_tgt;
         dma_idx_reg  <= '0;
      end
   end

   // Lockstep writes reach the standby too; a bus write beats the copy
   // at the same index so the copy never restores a stale byte.
   always_ff @(posedge ref_clk)
   begin
      if (dma_busy_reg)
         ram_reg[dma_tgt_reg][dma_idx_reg] <= ram_reg[~dma_tgt_reg][dma_idx_reg];
      if (ibus_wr && !par_err)
      begin
         ram_reg[act_reg][ibus_addr] <= ibus_i[DATA_W-1:0];
         if (sby_in || (dma_busy_reg && dma_tgt_reg == prt))
            ram_reg[prt][ibus_addr] <= ibus_i[DATA_W-1:0];
      end
   end

   // Bus driven toward the processor only on a read
   assign ibus_oe = {(DATA_W + 1){ibus_rd && !ibus_wr}};
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ibus_o <= '0;
      else if (ibus_rd)
         ibus_o <= {rd_par, ram_reg[act_reg][ibus_addr]};
   end

   // Scan reply
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sab_valid  <= 1'b0;
         sab_data   <= '0;
         sab_health <= 1'b0;
         sab_par    <= 1'b0;
         sab_chk    <= 1'b0;
      end
      else
      begin
         sab_valid <= scan_req && scan_normal;
         sab_par   <= 1'b0;
         sab_chk   <= 1'b0;
         if (scan_req && scan_normal)
         begin
            sab_data   <= scan_data;
            sab_health <= det_on;
            sab_par    <= ~scan_par;
            sab_chk    <= scan_ident;
         end
      end
   end

   assign active_ctl = act_reg;
   assign ctl0_state = st_reg[0];
   assign ctl1_state = st_reg[1];
   assign oos_lamp   = {!in_svc(st_reg[1]), !in_svc(st_reg[0])};
   assign dma_busy   = dma_busy_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_scan_parity: assert property (scan_req && scan_normal |=>
      sab_par == ~^$past(scan_data)) else $error("scan parity wrong");
   a_scan_check: assert property (scan_req && scan_normal |=>
      sab_chk == $past(scan_ident)) else $error("check request wrong");
   a_reply_gate: assert property (!(scan_req && scan_normal) |=>
      !sab_valid && !sab_par) else $error("reply without scan");
   a_one_out: assert property (!(oos_lamp[0] && oos_lamp[1]))
      else $error("both controllers out of service");
   a_lamp_on: assert property (rm_ok && !cc_force && !act_fault &&
      !sby_fault && !(diag_done && !diag_pass) |=> oos_lamp != 2'b00)
      else $error("removed controller lamp off");
   a_auto_swap: assert property (act_fault && !cc_force &&
      (st_reg[prt] == ST_STANDBY || st_reg[prt] == ST_OS_TEST ||
      st_reg[prt] == ST_OS_HAND || st_reg[prt] == ST_OUT_OF_SERVICE_FAULTED) |=>
      active_ctl != $past(active_ctl))
      else $error("no switch on active fault");
   a_par_fault: assert property (ibus_wr && ^ibus_i |=> fault_ind)
      else $error("parity error not flagged");
   a_diag_run: assert property (mis && !mis_reg |=> diag_start)
      else $error("mismatch did not start diagnostic");
   a_out_hold: assert property (det_on && out_mis |=>
      $stable(periph_out)) else $error("unmatched output released");
   a_bus_dir: assert property (ibus_wr |-> ibus_oe == '0)
      else $error("bus driven during write");
   a_order_tick: assert property (periph_cmd != '0 |-> $past(tick))
      else $error("order acted off cycle");
endmodule
`default_nettype wire

// *** inc/dcm_pkg.sv ***
// Constants, states and removal kinds of the duplex controller maintenance
// block. Assumes a single 250 MHz clock domain.
package dcm_pkg;
   localparam int CLK_MHZ   = 250;
   localparam int CYCLE_MS  = 10;
   // Cycles per ms is CLK_MHZ * 1000; keeps the product inside 32 bits
   localparam int CYCLE_CYC = CYCLE_MS * 1000 * CLK_MHZ;
   localparam int DATA_W    = 8;
   localparam int SAB_W     = 16;
   localparam int CMD_W     = 4;
   localparam int NCMD      = 2 ** CMD_W;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_ACTIVE_MAINTENANCE_REMOVED,
      ST_STANDBY,
      ST_OS_TEST,
      ST_OS_HAND,
      ST_OUT_OF_SERVICE_FAULTED,
      ST_OUT_OF_SERVICE_REMOVED,
      ST_FORCED
   } dcm_state_type;

   typedef enum logic [1:0] {
      RM_TEST,
      RM_HAND,
      RM_FORCED,
      RM_SUSPECT
   } dcm_rm_type;

   localparam logic          RST_ACT = 1'b0;
   localparam dcm_state_type RST_ST0 = ST_ACTIVE;
   localparam dcm_state_type RST_ST1 = ST_STANDBY;
endpackage

// *** test/dcm_cc_model.sv ***
// Central control side of the scan answer bus: counts replies and checks
// reply parity on request. Shares ref_clk with the block under test.
`timescale 1ns/1ps
`default_nettype none
module dcm_cc_model
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        sab_valid,
   input  wire logic [15:0] sab_data,
   input  wire logic        sab_par,
   input  wire logic        sab_chk,
   output logic      [7:0]  irq_count,
   output logic      [7:0]  reply_count
);
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_count   <= 8'h00;
         reply_count <= 8'h00;
      end
      else if (sab_valid)
      begin
         reply_count <= reply_count + 8'h01;
         // Parity pulse on even data makes data plus parity odd
         if (sab_chk && !(^{sab_data, sab_par}))
            irq_count <= irq_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

// *** test/dcm_tb_top.sv ***
// Self-checking bench for dcm_top with the central control model.
// Inputs change by NBA on the rising edge; outputs sampled on falling edge.
`timescale 1ns/1ps
`default_nettype none
module dcm_tb_top;
   import dcm_pkg::*;
   localparam int DEPTH = 16;
   logic ref_clk, nrst, ibus_rd, ibus_wr, ord_valid, link_app, rm_req, rm_ctl;
   logic rm_refused, rs_req, rs_ctl, cc_force, cc_force_ctl, diag_done;
   logic diag_ctl, diag_pass, diag_start, diag_target, active_ctl, dma_busy;
   logic fault_ind, scan_req, scan_normal, scan_ident, sab_valid, sab_health;
   logic sab_par, sab_chk;
   logic [3:0]  ibus_addr, ord_code, line_en;
   logic [8:0]  ibus_i, ibus_o, ibus_oe;
   logic [7:0]  ctl0_out, ctl1_out, hc0_a, hc0_b, hc1_a, hc1_b, periph_out;
   logic [7:0]  irq_count, reply_count;
   logic [15:0] periph_cmd, scan_data, sab_data;
   logic [1:0]  oos_lamp;
   dcm_rm_type    rm_kind;
   dcm_state_type ctl0_state, ctl1_state;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;

   dcm_top #(.DEPTH(DEPTH), .OW(8), .LINE_N(4), .CYCLE_LEN(8)) dcm_top_i (
      .ref_clk, .nrst, .ibus_addr, .ibus_rd, .ibus_wr, .ibus_i, .ibus_o,
      .ibus_oe, .ctl0_out, .ctl1_out, .hc0_a, .hc0_b, .hc1_a, .hc1_b,
      .periph_out, .ord_valid, .ord_code, .link_app, .periph_cmd, .line_en,
      .rm_req, .rm_ctl, .rm_kind, .rm_refused, .rs_req, .rs_ctl, .cc_force,
      .cc_force_ctl, .diag_done, .diag_ctl, .diag_pass, .diag_start,
      .diag_target, .active_ctl, .ctl0_state, .ctl1_state, .oos_lamp,
      .dma_busy, .fault_ind, .scan_req, .scan_normal, .scan_ident,
      .scan_data, .sab_valid, .sab_data, .sab_health, .sab_par, .sab_chk);

   dcm_cc_model dcm_cc_model_i (.ref_clk, .nrst, .sab_valid, .sab_data,
      .sab_par, .sab_chk, .irq_count, .reply_count);

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic remove(input logic c, input dcm_rm_type k);
      @(posedge ref_clk);
      rm_req  <= 1'b1;
      rm_ctl  <= c;
      rm_kind <= k;
      @(posedge ref_clk);
      rm_req <= 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic scan(input logic [15:0] d, input logic id, input logic hl);
      @(posedge ref_clk);
      scan_req    <= 1'b1;
      scan_normal <= 1'b1;
      scan_ident  <= id;
      scan_data   <= d;
      @(posedge ref_clk);
      scan_req <= 1'b0;
      @(negedge ref_clk);
      check(sab_valid, 1'b1);
      check(sab_data, d);
      check(sab_par, ~^d);
      check(sab_chk, id);
      check(sab_health, hl);
   endtask

   task automatic bus_xfer(input logic wr, input logic [3:0] a,
                           input logic [8:0] v);
      @(posedge ref_clk);
      ibus_addr <= a;
      ibus_wr   <= wr;
      ibus_rd   <= !wr;
      ibus_i    <= v;
      @(negedge ref_clk);
      check(ibus_oe, wr ? 9'h000 : 9'h1ff);
      @(posedge ref_clk);
      ibus_wr <= 1'b0;
      ibus_rd <= 1'b0;
      @(negedge ref_clk);
      if (!wr)
         check(ibus_o, v);
   endtask

   task automatic t_compare();
      int n;
      @(posedge ref_clk);
      ctl0_out <= 8'ha5;
      ctl1_out <= 8'ha5;
      repeat (3) @(negedge ref_clk);
      check(periph_out, 8'ha5);
      // Disturb the active side so a released word would show it
      @(posedge ref_clk);
      ctl0_out <= 8'h3c;
      @(posedge ref_clk);
      ctl0_out <= 8'ha5;
      for (n = 0; n < 10 && diag_start !== 1'b1; n++)
         @(negedge ref_clk);
      check(diag_start, 1'b1);
      check(periph_out, 8'ha5);
      check(diag_target, 1'b0);
      check(active_ctl, 1'b0);
   endtask

   task automatic t_orders();
      int n;
      for (int c = 0; c < 16; c++)
      begin
         @(posedge ref_clk);
         ord_valid <= 1'b1;
         ord_code  <= c[3:0];
         link_app  <= c[0];
         @(posedge ref_clk);
         ord_valid <= 1'b0;
         for (n = 0; n < 30 && periph_cmd === 16'h0000; n++)
            @(negedge ref_clk);
         check(periph_cmd, 16'h0001 << c);
         check(line_en, c[0] ? 4'h1 << c[1:0] : 4'h0);
      end
   endtask

   task automatic t_scan_and_bus();
      scan(16'h1234, 1'b1, 1'b1);
      scan(16'h0007, 1'b0, 1'b1);
      @(posedge ref_clk);
      scan_req    <= 1'b1;
      scan_normal <= 1'b0;
      @(posedge ref_clk);
      scan_req <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check(sab_valid, 1'b0);
      bus_xfer(1'b1, 4'h3, {^8'h6e, 8'h6e});
      bus_xfer(1'b1, 4'hf, {^8'h01, 8'h01});
      bus_xfer(1'b0, 4'h3, {^8'h6e, 8'h6e});
      bus_xfer(1'b0, 4'hf, {^8'h01, 8'h01});
   endtask

   // Restore by request or by a passed diagnostic; copy takes DEPTH cycles
   task automatic restore(input logic c, input logic by_diag);
      int n;
      @(posedge ref_clk);
      rs_req    <= !by_diag;
      diag_done <= by_diag;
      rs_ctl    <= c;
      diag_ctl  <= c;
      diag_pass <= 1'b1;
      @(posedge ref_clk);
      rs_req    <= 1'b0;
      diag_done <= 1'b0;
      @(negedge ref_clk);
      check(dma_busy, 1'b1);
      for (n = 0; n < 40 && dma_busy === 1'b1; n++)
         @(negedge ref_clk);
      check(n, DEPTH);
      check(c ? ctl1_state : ctl0_state, ST_STANDBY);
   endtask

   task automatic t_remove_restore();
      remove(1'b1, RM_TEST);
      check(ctl1_state, ST_OS_TEST);
      check(oos_lamp, 2'b10);
      remove(1'b0, RM_HAND);
      check(rm_refused, 1'b1);
      check(ctl0_state, ST_ACTIVE);
      // Byte held only by the active side; read back later from the copy
      bus_xfer(1'b1, 4'h9, {1'b0, 8'hc3});
      restore(1'b1, 1'b0);
      remove(1'b1, RM_FORCED);
      check(ctl1_state, ST_FORCED);
      restore(1'b1, 1'b0);
      remove(1'b1, RM_SUSPECT);
      check(ctl1_state, ST_OUT_OF_SERVICE_REMOVED);
      restore(1'b1, 1'b1);
   endtask

   task automatic t_faults();
      remove(1'b1, RM_HAND);
      check(ctl1_state, ST_OS_HAND);
      bus_xfer(1'b1, 4'h5, {~^8'h81, 8'h81});
      check(fault_ind, 1'b1);
      check(diag_start, 1'b1);
      check(diag_target, 1'b0);
      @(negedge ref_clk);
      check(active_ctl, 1'b1);
      check(ctl1_state, ST_ACTIVE);
      check(oos_lamp, 2'b01);
      bus_xfer(1'b0, 4'h9, {1'b0, 8'hc3});
      @(posedge ref_clk);
      diag_done <= 1'b1;
      diag_ctl  <= 1'b0;
      diag_pass <= 1'b0;
      @(posedge ref_clk);
      diag_done <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check(ctl0_state, ST_OUT_OF_SERVICE_FAULTED);
      @(posedge ref_clk);
      hc1_b <= 8'h5a;
      @(posedge ref_clk);
      hc1_b <= 8'h00;
      repeat (2) @(negedge ref_clk);
      check(active_ctl, 1'b0);
      check(ctl0_state, ST_ACTIVE_MAINTENANCE_REMOVED);
      check(diag_target, 1'b1);
      scan(16'hbeef, 1'b1, 1'b0);
      remove(1'b1, RM_TEST);
      check(rm_refused, 1'b1);
      // Central control overrides the pair's own choice
      @(posedge ref_clk);
      cc_force     <= 1'b1;
      cc_force_ctl <= 1'b1;
      @(posedge ref_clk);
      cc_force <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check(active_ctl, 1'b1);
      check(ctl1_state, ST_ACTIVE);
      check(ctl0_state, ST_OUT_OF_SERVICE_REMOVED);
      check(oos_lamp, 2'b01);
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         end_sim();
      end
   end

   initial
   begin
      {nrst, ibus_rd, ibus_wr, ord_valid, link_app, rm_req, rm_ctl} = '0;
      {rs_req, rs_ctl, cc_force, cc_force_ctl, diag_done, diag_ctl} = '0;
      {diag_pass, scan_req, scan_normal, scan_ident} = '0;
      {ibus_addr, ord_code, ibus_i, scan_data} = '0;
      {ctl0_out, ctl1_out, hc0_a, hc0_b, hc1_a, hc1_b} = '0;
      rm_kind = RM_TEST;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check(ctl0_state, ST_ACTIVE);
      check(ctl1_state, ST_STANDBY);
      check({active_ctl, oos_lamp, dma_busy}, 4'h0);
      t_compare();
      t_orders();
      t_scan_and_bus();
      t_remove_restore();
      t_faults();
      check(irq_count, 8'h00);
      check(reply_count, 8'h03);
      end_sim();
   end
endmodule
`default_nettype wire
